// ### logic/adcseq_map.vh
// register map, field positions, reset values and timing counts of the conversion sequencer
// assumes a 125 MHz core clock and word-aligned AXI4-Lite byte addresses
`ifndef ADCSEQ_MAP_VH
`define ADCSEQ_MAP_VH

// register indices; printed offsets are kept as indices, address = 4 * index
`define ADCSEQ_IDX_RESULT 8'h1e
`define ADCSEQ_IDX_CONTROL 8'h1f
`define ADCSEQ_IDX_PORTCFG 8'h9f
`define ADCSEQ_IDX_FLAGS 8'h0c
`define ADCSEQ_IDX_ENABLES 8'h8c
`define ADCSEQ_IDX_INTCTL 8'h0b
`define ADCSEQ_IDX_PORTA 8'h05
`define ADCSEQ_IDX_PORTE 8'h09
`define ADCSEQ_IDX_ANAIN 8'h40
`define ADCSEQ_IDX_SYSCTL 8'h41

// control register fields
`define ADCSEQ_CTL_ON 0
`define ADCSEQ_CTL_GO 2
`define ADCSEQ_CTL_CHLO 3
`define ADCSEQ_CTL_CLKLO 6
`define ADCSEQ_CTL_RESET 8'h00
`define ADCSEQ_CTL_MASK 8'hfd

// port configuration
`define ADCSEQ_PCFG_MASK 8'h07
`define ADCSEQ_PCFG_RESET 3'h0

// interrupt bits
`define ADCSEQ_DONE_BIT 6
`define ADCSEQ_PERIPHERAL_IRQ_ENABLE_BIT 6
`define ADCSEQ_GIE_BIT 7

// clock selection codes
`define ADCSEQ_CLK_DIV2 2'h0
`define ADCSEQ_CLK_DIV8 2'h1
`define ADCSEQ_CLK_DIV32 2'h2
`define ADCSEQ_CLK_RC 2'h3

// timing: half periods counted, 9.5 periods = 19 halves, 2 periods = 4 halves
`define ADCSEQ_CONV_HALVES 5'h13
`define ADCSEQ_WAIT_HALVES 5'h04
`define ADCSEQ_INSTR_CYCLES 4'h4
`define ADCSEQ_CLK_NS 8
`define ADCSEQ_RC_NS 4000
`define ADCSEQ_RC_HALF ((`ADCSEQ_RC_NS / 2) / `ADCSEQ_CLK_NS)
// divider limit for the rc half period, ADCSEQ_RC_HALF - 1 held at counter width
`define ADCSEQ_RC_LIM 9'h0f9

`endif

// ### logic/adcseq_tad_gen.v
// bit-period half tick generator for the conversion sequencer
// assumes clk is the core oscillator; rc source is modelled by a long divider
`timescale 1ns/1ps
`include "adcseq_map.vh"
module adcseq_tad_gen (
  input wire clk,
  input wire arst_n,
  input wire run,
  input wire [1:0] clkSel,
  output reg halfTick
);
  reg [8:0] cnt_ff;
  reg [8:0] lim;

  always @*
  begin
    case (clkSel)
      `ADCSEQ_CLK_DIV2: lim = 9'h000;
      `ADCSEQ_CLK_DIV8: lim = 9'h003;
      `ADCSEQ_CLK_DIV32: lim = 9'h00f;
      default: lim = `ADCSEQ_RC_LIM;
    endcase
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= 9'h000;
      halfTick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff <= 9'h000;
      halfTick <= 1'b0;
    end
    else if (cnt_ff >= lim)
    begin
      cnt_ff <= 9'h000;
      halfTick <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 9'h001;
      halfTick <= 1'b0;
    end
  end
endmodule // adcseq_tad_gen

// ### logic/adcseq_pin_cfg.v
// decodes the port role code into analog masks and reference choice
// pure combinational, read by the sequencer top
`timescale 1ns/1ps
`include "adcseq_map.vh"
module adcseq_pin_cfg (
  input wire [2:0] roleCode,
  output reg [7:0] analogMask,
  output reg extRef
);
  // mask order: ra0 ra1 ra2 ra3 ra5 re0 re1 re2 as bits 0..7
  always @*
  begin
    extRef = roleCode[0] & ~roleCode[2] | (roleCode == 3'h5);
    case (roleCode)
      3'h0: analogMask = 8'hff;
      3'h1: analogMask = 8'hf7;
      3'h2: analogMask = 8'h1f;
      3'h3: analogMask = 8'h17;
      3'h4: analogMask = 8'h0b;
      3'h5: analogMask = 8'h03;
      default: analogMask = 8'h00;
    endcase
  end
endmodule // adcseq_pin_cfg

// ### logic/adcseq_top.v
// conversion sequencer of an 8-bit successive-approximation converter with AXI4-Lite registers
// assumes a single 125 MHz clock; the analog comparator result arrives as an 8-bit sampled word
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adcseq_map.vh"

// Notes on behaviour
// - port code picks supply or pin reference
// - port code assigns analog and digital pins
// - config bits 7..3 ignore writes, read zero
// - conversion lasts nine and a half periods
// - period from osc x2, x8, x32, rc
// - two periods pass before next acquisition
// - setting start flag while on converts
// - completion clears start, loads result together
// - done flag; irq needs three enables
// - clearing start aborts, result kept
// - after abort wait two periods, reacquire
// - analog pins read zero on port data
// - rc clock delays one instruction first
// - rc completion in sleep wakes if enabled
// - non-rc sleep aborts and powers down
// - reset disables, aborts, pins analog
// - result not cleared by reset
// - clock select codes 00..11 mapping
// - channel select picks channel by value
module adcseq_top (
  input wire clk,
  input wire arst_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleepIn,
  input wire [5:0] portAPins,
  input wire [2:0] portEPins,
  input wire [7:0] sampleCode,
  output reg [2:0] channelSelect,
  output reg samplingOn,
  output reg extRefOn,
  output reg [7:0] analogPins,
  output reg irqOut,
  output reg wakeOut
);
  localparam ST_OFF = 3'h0;
  localparam ST_ACQ = 3'h1;
  localparam ST_DLY = 3'h2;
  localparam ST_CONV = 3'h3;
  localparam ST_WAIT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] control_ff;
  reg [2:0] portCfg_ff;
  reg [7:0] result_ff;
  reg doneFlag_ff;
  reg irqEn_ff;
  reg [1:0] intCtl_ff;
  reg [2:0] state_ff;
  reg [4:0] halves_ff;
  reg [3:0] instr_ff;
  reg [31:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg awHave_ff;
  reg wHave_ff;
  reg [2:0] nxt_state;
  reg [4:0] nxt_halves;
  reg [3:0] nxt_instr;
  reg nxt_done;
  reg nxt_abort;
  reg [7:0] rdWord;
  reg rdOk;
  wire halfTick;
  wire [7:0] anaMask;
  wire extRef;
  wire isOn = control_ff[`ADCSEQ_CTL_ON];
  wire isGo = control_ff[`ADCSEQ_CTL_GO];
  wire [1:0] clkSel = control_ff[`ADCSEQ_CTL_CLKLO +: 2];
  wire rcClk = (clkSel == `ADCSEQ_CLK_RC);
  wire powerDown = !isOn || (sleepIn && !rcClk);
  wire doWrite = awHave_ff && wHave_ff && !s_axi_bvalid;
  wire [7:0] wIdx = awAddr_ff[9:2];
  wire ctlWr = doWrite && wIdx == `ADCSEQ_IDX_CONTROL && wStrb_ff[0];

  function [7:0] lowByte;
    input [31:0] word;
    lowByte = word[7:0];
  endfunction

  function hitIdx;
    input [31:0] addr;
    input [7:0] idx;
    hitIdx = (addr[31:10] == 22'h000000) && (addr[9:2] == idx);
  endfunction

  adcseq_tad_gen u_tad (
    .clk(clk),
    .arst_n(arst_n),
    .run(state_ff == ST_CONV || state_ff == ST_WAIT),
    .clkSel(clkSel),
    .halfTick(halfTick)
  );

  adcseq_pin_cfg u_pins (
    .roleCode(portCfg_ff),
    .analogMask(anaMask),
    .extRef(extRef)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always @*
  begin
    nxt_state = state_ff;
    nxt_halves = halves_ff;
    nxt_instr = instr_ff;
    nxt_done = 1'b0;
    nxt_abort = 1'b0;
    case (state_ff)
      ST_OFF:
        if (!powerDown)
          nxt_state = ST_ACQ;
      ST_ACQ:
        if (isGo)
        begin
          nxt_instr = 4'h0;
          nxt_halves = 5'h00;
          nxt_state = rcClk ? ST_DLY : ST_CONV;
        end
      ST_DLY:
        if (!isGo)
          nxt_state = ST_ACQ;
        else if (instr_ff == `ADCSEQ_INSTR_CYCLES - 4'h1)
          nxt_state = ST_CONV;
        else
          nxt_instr = instr_ff + 4'h1;
      ST_CONV:
        if (!isGo)
        begin
          nxt_abort = 1'b1;
          nxt_halves = 5'h00;
          nxt_state = ST_WAIT;
        end
        else if (halfTick)
        begin
          if (halves_ff == `ADCSEQ_CONV_HALVES - 5'h01)
          begin
            nxt_done = 1'b1;
            nxt_halves = 5'h00;
            nxt_state = ST_WAIT;
          end
          else
            nxt_halves = halves_ff + 5'h01;
        end
      ST_WAIT:
        if (halfTick)
        begin
          if (halves_ff == `ADCSEQ_WAIT_HALVES - 5'h01)
            nxt_state = ST_ACQ;
          else
            nxt_halves = halves_ff + 5'h01;
        end
      default:
        nxt_state = ST_OFF;
    endcase
    if (powerDown)
      nxt_state = ST_OFF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always @*
  begin
    rdWord = 8'h00;
    rdOk = 1'b1;
    if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_CONTROL))
      rdWord = control_ff;
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_PORTCFG))
      rdWord = {5'h00, portCfg_ff};
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_RESULT))
      rdWord = result_ff;
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_FLAGS))
      rdWord = {1'b0, doneFlag_ff, 6'h00};
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_ENABLES))
      rdWord = {1'b0, irqEn_ff, 6'h00};
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_INTCTL))
      rdWord = {intCtl_ff, 6'h00};
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_PORTA))
      rdWord = {2'h0, portAPins[5] & ~anaMask[4], portAPins[4],
        portAPins[3:0] & ~anaMask[3:0]};
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_PORTE))
      rdWord = {5'h00, portEPins & ~anaMask[7:5]};
    else if (hitIdx(s_axi_araddr, `ADCSEQ_IDX_ANAIN))
      rdWord = {5'h00, state_ff};
    else
      rdOk = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 32'h00000000;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !awHave_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHave_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_ff[31:10] == 22'h000000) ? 2'h0 : 2'h2;
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdWord};
        s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // register file; reset puts every register except the result to its reset value
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      control_ff <= `ADCSEQ_CTL_RESET;
      portCfg_ff <= `ADCSEQ_PCFG_RESET;
      doneFlag_ff <= 1'b0;
      irqEn_ff <= 1'b0;
      intCtl_ff <= 2'h0;
      state_ff <= ST_OFF;
      halves_ff <= 5'h00;
      instr_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      halves_ff <= nxt_halves;
      instr_ff <= nxt_instr;
      if (ctlWr)
        // start only counts once the converter was already on
        control_ff <= (lowByte(wData_ff) & `ADCSEQ_CTL_MASK)
          & ~({5'h00, !isOn, 2'h0});
      if (nxt_done)
        control_ff[`ADCSEQ_CTL_GO] <= 1'b0;
      // a sleep abort drops the start too, so waking does not resume a stale conversion
      if (powerDown)
        control_ff[`ADCSEQ_CTL_GO] <= 1'b0;
      if (doWrite && wIdx == `ADCSEQ_IDX_PORTCFG && wStrb_ff[0])
        portCfg_ff <= wData_ff[2:0];
      if (doWrite && wIdx == `ADCSEQ_IDX_ENABLES && wStrb_ff[0])
        irqEn_ff <= wData_ff[`ADCSEQ_DONE_BIT];
      if (doWrite && wIdx == `ADCSEQ_IDX_INTCTL && wStrb_ff[0])
        intCtl_ff <= wData_ff[7:6];
      // set wins over a software clear in the same cycle
      if (nxt_done)
        doneFlag_ff <= 1'b1;
      else if (doWrite && wIdx == `ADCSEQ_IDX_FLAGS && wStrb_ff[0])
        doneFlag_ff <= wData_ff[`ADCSEQ_DONE_BIT];
    end
  end

  // result keeps no reset: content is unknown after power-on
  always @(posedge clk)
  begin
    if (nxt_done)
      result_ff <= sampleCode;
    else if (doWrite && wIdx == `ADCSEQ_IDX_RESULT && wStrb_ff[0])
      result_ff <= wData_ff[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      channelSelect <= 3'h0;
      samplingOn <= 1'b0;
      extRefOn <= 1'b0;
      analogPins <= 8'hff;
      irqOut <= 1'b0;
      wakeOut <= 1'b0;
    end
    else
    begin
      channelSelect <= control_ff[`ADCSEQ_CTL_CHLO +: 3];
      samplingOn <= (nxt_state == ST_ACQ) || (nxt_state == ST_DLY);
      extRefOn <= extRef;
      analogPins <= anaMask;
      irqOut <= doneFlag_ff && irqEn_ff && intCtl_ff[0] && intCtl_ff[1];
      wakeOut <= sleepIn && doneFlag_ff && irqEn_ff;
    end
  end
endmodule // adcseq_top

// ### verif/adcseq_monitor.sv
// port checker of the conversion sequencer
// assumes binding onto adcseq_top, one clock domain
`timescale 1ns/1ps
module adcseq_monitor (
  input wire clk,
  input wire arst_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleepIn,
  input wire extRefOn,
  input wire [7:0] analogPins,
  input wire irqOut,
  input wire wakeOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_supply;
    !extRefOn |-> analogPins inside {8'hff, 8'h1f, 8'h0b, 8'h00};
  endproperty
  a_supply: assert property (p_supply) else $error("supply mask wrong");
  property p_masks;
    analogPins inside {8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00};
  endproperty
  a_masks: assert property (p_masks) else $error("mask not a role code");
  property p_rst;
    $rose(arst_n) |-> analogPins == 8'hff && !extRefOn && !irqOut;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_wake;
    wakeOut |-> $past(sleepIn);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without sleep");
  property p_irqwake;
    irqOut && $past(sleepIn) |-> wakeOut;
  endproperty
  a_irqwake: assert property (p_irqwake) else $error("no wake on irq");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule // adcseq_monitor
bind adcseq_top adcseq_monitor i_adcseq_monitor (.*);

// ### verif/tb.sv
// self-checking bench of the conversion sequencer
// assumes adcseq_top registers at byte address four times the index
`timescale 1ns/1ps
`include "adcseq_map.vh"
module tb;
  logic clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleepIn;
  logic irqOut, wakeOut, samplingOn, extRefOn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrs;
  logic [3:0] s_axi_wstrb;
  logic [5:0] portAPins;
  logic [2:0] portEPins, channelSelect, ch;
  logic [7:0] sampleCode, analogPins, m;
  logic [7:0] maskTab [8] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00, 8'h00};
  localparam logic [7:0] CT = `ADCSEQ_IDX_CONTROL;
  localparam logic [7:0] PC = `ADCSEQ_IDX_PORTCFG;
  localparam logic [7:0] RS = `ADCSEQ_IDX_RESULT;
  localparam logic [7:0] FL = `ADCSEQ_IDX_FLAGS;
  int n_fail, samples_checked, cyc, mRes, dt, h;
  adcseq_top i_adcseq_top (.*);
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  //////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    finish_test;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // one edge first so valid never drops and rises in one step
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    int n;
    logic a, w, b;
    @(posedge clk);
    n = 0;
    b = 0;
    s_axi_awaddr <= {22'h0, i, 2'b0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b)
    begin
      @(negedge clk);
      a = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      @(posedge clk);
      if (a) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (b) s_axi_bready <= 0;
      if (++n > 500) hang;
    end
  endtask
  task automatic rd(input logic [7:0] i);
    int n;
    logic a, r;
    @(posedge clk);
    n = 0;
    r = 0;
    s_axi_araddr <= {22'h0, i, 2'b0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!r)
    begin
      @(negedge clk);
      a = s_axi_arready;
      r = s_axi_rvalid;
      rdv = s_axi_rdata;
      rrs = s_axi_rresp;
      @(posedge clk);
      if (a) s_axi_arvalid <= 0;
      if (r) s_axi_rready <= 0;
      if (++n > 500) hang;
    end
  endtask
  task automatic conv(input int k);
    int t0;
    ch = 3'($urandom);
    h = k == 3 ? 250 : 1 << (2 * k);
    wr(CT, {k[1:0], ch, 3'b001});
    repeat (2000) @(posedge clk);
    sampleCode <= 8'($urandom);
    wr(CT, {k[1:0], ch, 3'b101});
    t0 = cyc;
    rdv = 4;
    while (rdv[2])
    begin
      rd(CT);
      if (cyc - t0 > 9000) hang;
    end
    dt = cyc - t0;
  endtask
  //////////////////////////////////////////////////////////////////
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleepIn} = 0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
    s_axi_wstrb = 4'h1;
    portAPins = 0;
    portEPins = 0;
    sampleCode = 0;
    arst_n = 0;
    void'($urandom(10618));
    repeat (4) @(posedge clk);
    arst_n <= 1;
    rd(PC);
    chk("portcfg", rdv, 0);
    rd(CT);
    chk("control", rdv, 0);
    chk("pins", analogPins, 8'hff);
    for (int c = 0; c < 8; c++)
    begin
      portAPins <= 6'($urandom);
      portEPins <= 3'($urandom);
      wr(PC, 8'($urandom) & 8'hf8 | 8'(c));
      rd(PC);
      chk("portcfg", rdv, c);
      m = maskTab[c];
      chk("pins", analogPins, m);
      chk("extref", extRefOn, c % 2 == 1 && c < 6);
      rd(`ADCSEQ_IDX_PORTA);
      chk("porta", rdv, portAPins & ~{m[4], 1'b0, m[3], m[2:0]});
      rd(`ADCSEQ_IDX_PORTE);
      chk("porte", rdv, portEPins & ~m[7:5]);
    end
    wr(PC, 0);
    wr(CT, 8'h05);
    rd(CT);
    chk("start", rdv[2], 0);
    wr(`ADCSEQ_IDX_ENABLES, 8'h40);
    wr(`ADCSEQ_IDX_INTCTL, 8'hc0);
    for (int k = 0; k < 5; k++)
    begin
      conv(k % 4);
      mRes = sampleCode;
      chk("time", dt >= 19 * h - 6 && dt <= 20 * h + 40, 1);
      chk("chan", channelSelect, ch);
      rd(RS);
      chk("result", rdv, mRes);
      rd(FL);
      chk("done", rdv[6], 1);
      if (k == 3)
      begin
        // abort mid-conversion, then the k == 4 pass restarts cleanly
        wr(RS, 8'(mRes + 1));
        mRes = mRes + 1 & 255;
        repeat (1100) @(posedge clk);
        wr(CT, 8'h8d);
        repeat (50) @(posedge clk);
        wr(CT, 8'h89);
        rd(RS);
        chk("abort", rdv, mRes);
        chk("waitacq", samplingOn, 0);
        repeat (100) @(posedge clk);
        chk("reacq", samplingOn, 1);
      end
    end
    @(negedge clk);
    chk("irq", irqOut, 1);
    @(posedge clk);
    sleepIn <= 1;
    repeat (3) @(negedge clk);
    chk("wake", wakeOut, 1);
    @(posedge clk);
    sleepIn <= 0;
    wr(`ADCSEQ_IDX_INTCTL, 8'h40);
    repeat (3) @(negedge clk);
    chk("irq", irqOut, 0);
    wr(FL, 0);
    rd(FL);
    chk("done", rdv[6], 0);
    sampleCode <= ~sampleCode;
    repeat (100) @(posedge clk);
    wr(CT, 8'h8d);
    sleepIn <= 1;
    repeat (400) @(posedge clk);
    sleepIn <= 0;
    rd(CT);
    chk("on", rdv[0], 1);
    chk("sleepgo", rdv[2], 0);
    rd(RS);
    chk("sleep", rdv, mRes);
    rd(`ADCSEQ_IDX_SYSCTL);
    chk("resp", rrs, 2);
    finish_test;
  end
  initial
  begin
    #700us;
    hang;
  end
endmodule // tb
